// ===== design/tcc_timer_channel.sv
// Notes on behaviour
// - Output value status shows programmed B, A and count-pin values in bits 16..18.
// - Pin level status shows the real level on each of the three pins.
// - Open-drain set and clear registers change per-pin state; status shows it.
// - Clock gate bit 0 turns the pin logic clock on or off; status reports it.
// - Clock gate bit 1 gates timer and divider; status bit 1 reports it.
// - Mode bit 15 zero selects capture; it resets to zero.
// - In capture mode lines A and B are always inputs.
// - Selected line A edges load capture A, capture B, or trigger the counter.
// - A writable 16-bit compare C register is compared with the counter.
// - Loading capture B may disable the counter clock and/or stop the counter.
// - Counter clock is core clock /2,/8,/32,/128,/1024 or one of three externals.
// - Burst option gates the selected clock with an external clock level.
// - Six events: trigger, A loaded, B loaded, overflow, overrun, compare C.
// - Overflow is flagged when the counter wraps from ffff to 0000.
// - Overrun is flagged when a capture reloads before its last value was read.
// - Compare C is flagged on the tick that takes the counter to compare C; with mode bit 14 set that tick restarts it at 0000 instead.
// - A write with sync bit 0 set triggers the counter at its next tick when clock enabled.
// - Command bit 0 resets the whole channel except clock gate status.
// - Command bit 1 enables counter clock unless bit 2 also set; bit 2 disables.
// - Command bit 3 triggers the counter at its next tick when clock enabled.
// - On an external clock the counter advances once per rising edge, or once per falling edge when mode bit 3 is set.
// - Reading status clears event flags and pin change flags.
// - Trigger comes from line A or B; edge code 00 none 01 rise 10 fall 11 both.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.svh"

module tcc_timer_channel (
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, 1 for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB transfer done
  output logic pslverr, // APB error, unmapped address
  input wire logic timer_line_a_in, // line A pin level
  output logic timer_line_a_out, // line A drive value
  output logic timer_line_a_oe, // line A drive enable
  input wire logic timer_line_b_in, // line B pin level
  output logic timer_line_b_out, // line B drive value
  output logic timer_line_b_oe, // line B drive enable
  input wire logic external_count_input_in, // count pin level, also external clock 0
  output logic external_count_input_out, // count pin drive value
  output logic external_count_input_oe, // count pin drive enable
  input wire logic ext_clock_1, // external clock 1
  input wire logic ext_clock_2 // external clock 2
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Index 0 line B, 1 line A, 2 count pin, 3 ext clock 1, 4 ext clock 2.
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_prev <= 5'h00;
    end else begin
      pin_meta <= {ext_clock_2, ext_clock_1, external_count_input_in, timer_line_a_in,
                   timer_line_b_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // One wait state: prdata is captured with pready so every output is a flop.
  logic acc;
  logic done;
  logic wr_done;
  logic rd_done;
  assign acc = psel & penable;
  assign done = acc & pready;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;

  function automatic logic wr_at(input logic [11:0] a, input logic [11:0] off);
    wr_at = (a == off);
  endfunction

  logic soft_rst;
  assign soft_rst = wr_done & wr_at(paddr, `TCC_CR) & pwdata[`TCC_CMD_SRST];

  // ---------------------------------------------------------------
  // Pin control registers
  // ---------------------------------------------------------------
  logic [2:0] out_value;
  logic [2:0] open_drain;
  logic [31:0] mode;
  logic pins_clk_on;
  logic timer_clk_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_value <= 3'h0;
      open_drain <= 3'h0;
    end else if (soft_rst) begin
      out_value <= 3'h0;
      open_drain <= 3'h0;
    end else if (wr_done) begin
      if (wr_at(paddr, `TCC_ODSET)) begin
        out_value <= out_value | pwdata[`TCC_PIN_MSB:`TCC_PIN_LSB];
      end else if (wr_at(paddr, `TCC_ODCLR)) begin
        out_value <= out_value & ~pwdata[`TCC_PIN_MSB:`TCC_PIN_LSB];
      end else if (wr_at(paddr, `TCC_MDER)) begin
        open_drain <= open_drain | pwdata[`TCC_PIN_MSB:`TCC_PIN_LSB];
      end else if (wr_at(paddr, `TCC_MDDR)) begin
        open_drain <= open_drain & ~pwdata[`TCC_PIN_MSB:`TCC_PIN_LSB];
      end
    end
  end

  // Clock gate status survives a channel soft reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_clk_on <= 1'b0;
      timer_clk_on <= 1'b0;
    end else if (wr_done && wr_at(paddr, `TCC_ECR)) begin
      pins_clk_on <= pins_clk_on | pwdata[`TCC_PINS_CLK];
      timer_clk_on <= timer_clk_on | pwdata[`TCC_TIMER_CLK];
    end else if (wr_done && wr_at(paddr, `TCC_DCR)) begin
      pins_clk_on <= pins_clk_on & ~pwdata[`TCC_PINS_CLK];
      timer_clk_on <= timer_clk_on & ~pwdata[`TCC_TIMER_CLK];
    end
  end

  // Open drain pulls low only; lines A and B never drive while in capture mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_line_a_out <= 1'b0;
      timer_line_b_out <= 1'b0;
      external_count_input_out <= 1'b0;
      timer_line_a_oe <= 1'b0;
      timer_line_b_oe <= 1'b0;
      external_count_input_oe <= 1'b0;
    end else begin
      timer_line_b_out <= out_value[0];
      timer_line_a_out <= out_value[1];
      external_count_input_out <= out_value[2];
      timer_line_b_oe <= mode[`TCC_MR_WAVE] & open_drain[0] & ~out_value[0];
      timer_line_a_oe <= mode[`TCC_MR_WAVE] & open_drain[1] & ~out_value[1];
      external_count_input_oe <= open_drain[2] & ~out_value[2];
    end
  end

  // ---------------------------------------------------------------
  // Mode and compare registers
  // ---------------------------------------------------------------
  logic [15:0] compare_c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 32'h0000_0000;
      compare_c <= 16'h0000;
    end else if (soft_rst) begin
      mode <= 32'h0000_0000;
      compare_c <= 16'h0000;
    end else if (wr_done && wr_at(paddr, `TCC_MR)) begin
      mode <= pwdata & `TCC_MR_MASK;
    end else if (wr_done && wr_at(paddr, `TCC_CMP_C)) begin
      compare_c <= pwdata[15:0];
    end
  end

  tcc_pkg::tcc_clksel_e clk_sel;
  assign clk_sel = tcc_pkg::tcc_clksel_e'(mode[2:0]);

  // ---------------------------------------------------------------
  // Counter clock source
  // ---------------------------------------------------------------
  // The divider runs only while the timer clock gate is on.
  logic [`TCC_PRESC_W-1:0] presc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
    end else if (soft_rst) begin
      presc <= '0;
    end else if (timer_clk_on) begin
      presc <= presc + 1'b1;
    end
  end

  logic [2:0] xc_level;
  logic [2:0] xc_edge;
  logic src_tick;
  logic burst_gate;
  logic cnt_tick;
  assign xc_level = {pin_sync[4], pin_sync[3], pin_sync[2]};
  // Inverted clock counts on falling edges of the external source.
  assign xc_edge = mode[`TCC_MR_CLKI] ? {pin_fall[4], pin_fall[3], pin_fall[2]}
                                      : {pin_rise[4], pin_rise[3], pin_rise[2]};

  always_comb begin
    case (clk_sel)
      tcc_pkg::TCC_DIV2: src_tick = &presc[0:0];
      tcc_pkg::TCC_DIV8: src_tick = &presc[2:0];
      tcc_pkg::TCC_DIV32: src_tick = &presc[4:0];
      tcc_pkg::TCC_DIV128: src_tick = &presc[6:0];
      tcc_pkg::TCC_DIV1024: src_tick = &presc[9:0];
      tcc_pkg::TCC_XC0: src_tick = xc_edge[0];
      tcc_pkg::TCC_XC1: src_tick = xc_edge[1];
      default: src_tick = xc_edge[2];
    endcase
  end

  always_comb begin
    case (mode[5:4])
      2'b00: burst_gate = 1'b1;
      2'b01: burst_gate = xc_level[0];
      2'b10: burst_gate = xc_level[1];
      default: burst_gate = xc_level[2];
    endcase
  end

  logic clk_enabled;
  assign cnt_tick = src_tick & burst_gate & timer_clk_on & clk_enabled;

  // ---------------------------------------------------------------
  // Capture, trigger and counter
  // ---------------------------------------------------------------
  tcc_pkg::tcc_run_e run;
  logic [15:0] count;
  logic [15:0] capture_a;
  logic [15:0] capture_b;
  logic trg_pending;
  logic a_armed;
  logic a_unread;
  logic b_unread;

  logic trg_rise;
  logic trg_fall;
  logic ext_trg;
  logic load_a;
  logic load_b;
  logic b_halts;
  logic cpc_evt;
  logic ovf_evt;
  logic trg_req;
  logic cmd_wr;
  logic sync_wr;

  assign cmd_wr = wr_done & wr_at(paddr, `TCC_CR);
  assign sync_wr = wr_done & wr_at(paddr, `TCC_SYNC) & pwdata[`TCC_SYNC_BIT];
  assign trg_rise = mode[`TCC_MR_TRGLINE] ? pin_rise[1] : pin_rise[0];
  assign trg_fall = mode[`TCC_MR_TRGLINE] ? pin_fall[1] : pin_fall[0];
  assign ext_trg = edge_hit(mode[9:8], trg_rise, trg_fall);
  assign load_a = clk_enabled & edge_hit(mode[17:16], pin_rise[1], pin_fall[1]);
  // Capture B waits until capture A has been loaded since the last trigger or the last load of capture B.
  assign load_b = clk_enabled & a_armed & edge_hit(mode[19:18], pin_rise[1], pin_fall[1]);
  assign b_halts = load_b & (mode[`TCC_MR_LDBSTOP] | mode[`TCC_MR_LDBDIS]);
  assign cpc_evt = cnt_tick & ~trg_pending & (run == tcc_pkg::TCC_COUNTING) &
                   (count + 16'h0001 == compare_c);
  assign ovf_evt = cnt_tick & ~trg_pending & (run == tcc_pkg::TCC_COUNTING) &
                   (count == `TCC_CNT_MAX);
  // A trigger edge that also halts via capture B is dropped.
  assign trg_req = clk_enabled & ~b_halts &
                   ((cmd_wr & pwdata[`TCC_CMD_TRIG]) | sync_wr | ext_trg |
                    (mode[`TCC_MR_CPCTRG] & cpc_evt));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_enabled <= 1'b0;
    end else if (soft_rst) begin
      clk_enabled <= 1'b0;
    end else if ((cmd_wr && pwdata[`TCC_CMD_CLKOFF]) || (load_b && mode[`TCC_MR_LDBDIS])) begin
      clk_enabled <= 1'b0;
    end else if (cmd_wr && pwdata[`TCC_CMD_CLKON]) begin
      clk_enabled <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= tcc_pkg::TCC_HALTED;
      count <= 16'h0000;
      trg_pending <= 1'b0;
    end else if (soft_rst) begin
      run <= tcc_pkg::TCC_HALTED;
      count <= 16'h0000;
      trg_pending <= 1'b0;
    end else if (b_halts) begin
      run <= tcc_pkg::TCC_HALTED;
      trg_pending <= 1'b0;
    end else begin
      case (run)
        tcc_pkg::TCC_HALTED: begin
          if (cnt_tick && (trg_pending || trg_req)) begin
            count <= 16'h0000;
            run <= tcc_pkg::TCC_COUNTING;
            trg_pending <= 1'b0;
          end else if (trg_req) begin
            trg_pending <= 1'b1;
          end
        end
        default: begin
          if (cnt_tick && (trg_pending || trg_req)) begin
            count <= 16'h0000;
            trg_pending <= 1'b0;
          end else if (cnt_tick) begin
            count <= count + 16'h0001;
          end else if (trg_req) begin
            trg_pending <= 1'b1;
          end
        end
      endcase
      if (!clk_enabled) begin
        trg_pending <= 1'b0;
      end
    end
  end

  logic rd_cap_a;
  logic rd_cap_b;
  assign rd_cap_a = rd_done & wr_at(paddr, `TCC_CAP_A);
  assign rd_cap_b = rd_done & wr_at(paddr, `TCC_CAP_B);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_a <= 16'h0000;
      capture_b <= 16'h0000;
      a_armed <= 1'b0;
      a_unread <= 1'b0;
      b_unread <= 1'b0;
    end else if (soft_rst) begin
      capture_a <= 16'h0000;
      capture_b <= 16'h0000;
      a_armed <= 1'b0;
      a_unread <= 1'b0;
      b_unread <= 1'b0;
    end else begin
      if (load_a) begin
        capture_a <= count;
      end else if (wr_done && wr_at(paddr, `TCC_CAP_A)) begin
        capture_a <= pwdata[15:0];
      end
      if (load_b) begin
        capture_b <= count;
      end else if (wr_done && wr_at(paddr, `TCC_CAP_B)) begin
        capture_b <= pwdata[15:0];
      end
      a_armed <= load_a | (a_armed & ~load_b & ~trg_req);
      a_unread <= load_a | (a_unread & ~rd_cap_a);
      b_unread <= load_b | (b_unread & ~rd_cap_b);
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // A new event in the reading cycle stays set for the next read.
  logic rd_sr;
  logic [5:0] evt_flags;
  logic [5:0] evt_set;
  logic [2:0] pin_changed;
  assign rd_sr = rd_done & wr_at(paddr, `TCC_SR);
  // Order: trigger, load B, load A, compare C, overrun, overflow.
  assign evt_set = {ext_trg & clk_enabled, load_b, load_a, cpc_evt,
                    (load_a & a_unread) | (load_b & b_unread), ovf_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_flags <= 6'h00;
      pin_changed <= 3'h0;
    end else if (soft_rst) begin
      evt_flags <= 6'h00;
      pin_changed <= 3'h0;
    end else begin
      // The read clears only what prdata reported, so a flag set after the snapshot survives.
      evt_flags <= (rd_sr ? (evt_flags & ~{prdata[7:4], prdata[1:0]}) : evt_flags) |
                   evt_set;
      pin_changed <= (rd_sr ? (pin_changed & prdata[`TCC_PIN_MSB:`TCC_PIN_LSB]) :
                      pin_changed) |
                     ({3{pins_clk_on}} & (pin_rise[2:0] | pin_fall[2:0]));
    end
  end

  // ---------------------------------------------------------------
  // Read mux and response
  // ---------------------------------------------------------------
  logic [31:0] rd_val;
  logic rd_hit;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == `TCC_ODSR) begin
      rd_val[`TCC_PIN_MSB:`TCC_PIN_LSB] = out_value;
    end else if (paddr == `TCC_PDSR) begin
      rd_val[`TCC_PIN_MSB:`TCC_PIN_LSB] = pin_sync[2:0];
    end else if (paddr == `TCC_MDSR) begin
      rd_val[`TCC_PIN_MSB:`TCC_PIN_LSB] = open_drain;
    end else if (paddr == `TCC_PMSR) begin
      rd_val[`TCC_TIMER_CLK:`TCC_PINS_CLK] = {timer_clk_on, pins_clk_on};
    end else if (paddr == `TCC_MR) begin
      rd_val = mode;
    end else if (paddr == `TCC_SR) begin
      rd_val[7:4] = evt_flags[5:2];
      rd_val[1:0] = evt_flags[1:0];
      rd_val[`TCC_SR_CLKSTA] = clk_enabled;
      rd_val[`TCC_SR_MTIOA] = pin_sync[1];
      rd_val[`TCC_SR_MTIOB] = pin_sync[0];
      rd_val[`TCC_PIN_MSB:`TCC_PIN_LSB] = ~pin_changed; // 1 means no change seen.
    end else if (paddr == `TCC_CV) begin
      rd_val[15:0] = count;
    end else if (paddr == `TCC_CAP_A) begin
      rd_val[15:0] = capture_a;
    end else if (paddr == `TCC_CAP_B) begin
      rd_val[15:0] = capture_b;
    end else if (paddr == `TCC_CMP_C) begin
      rd_val[15:0] = compare_c;
    end else if ((paddr == `TCC_ODSET) || (paddr == `TCC_ODCLR) || (paddr == `TCC_MDER) ||
                 (paddr == `TCC_MDDR) || (paddr == `TCC_ECR) || (paddr == `TCC_DCR) ||
                 (paddr == `TCC_CR) || (paddr == `TCC_SYNC)) begin
      rd_val = 32'h0000_0000;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (acc && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= ~rd_hit;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== design/tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Register byte offsets.
`define TCC_ODSET 12'h030
`define TCC_ODCLR 12'h034
`define TCC_ODSR 12'h038
`define TCC_PDSR 12'h03c
`define TCC_MDER 12'h040
`define TCC_MDDR 12'h044
`define TCC_MDSR 12'h048
`define TCC_ECR 12'h050
`define TCC_DCR 12'h054
`define TCC_PMSR 12'h058
`define TCC_CR 12'h060
`define TCC_MR 12'h064
`define TCC_SR 12'h070
`define TCC_CV 12'h080
`define TCC_CAP_A 12'h084
`define TCC_CAP_B 12'h088
`define TCC_CMP_C 12'h08c
`define TCC_SYNC 12'h300

// Pin field: bit 16 line B, 17 line A, 18 external count input.
`define TCC_PIN_LSB 16
`define TCC_PIN_MSB 18

// Clock gate bits.
`define TCC_PINS_CLK 0
`define TCC_TIMER_CLK 1

// Command bits.
`define TCC_CMD_SRST 0
`define TCC_CMD_CLKON 1
`define TCC_CMD_CLKOFF 2
`define TCC_CMD_TRIG 3
`define TCC_SYNC_BIT 0

// Mode fields.
`define TCC_MR_MASK 32'h000f_c7ff
`define TCC_MR_CLKI 3
`define TCC_MR_LDBSTOP 6
`define TCC_MR_LDBDIS 7
`define TCC_MR_TRGLINE 10
`define TCC_MR_CPCTRG 14
`define TCC_MR_WAVE 15

// Status layout: six events in [7:4],[1:0], clock status 8, mirrors 9/10, pins 16..18.
`define TCC_SR_CLKSTA 8
`define TCC_SR_MTIOA 9
`define TCC_SR_MTIOB 10

`define TCC_CNT_MAX 16'hffff
`define TCC_PRESC_W 10

`endif

// ===== design/tcc_pkg.sv
package tcc_pkg;

  typedef enum logic [0:0] {
    TCC_HALTED = 1'b0,
    TCC_COUNTING = 1'b1
  } tcc_run_e;

  typedef enum logic [2:0] {
    TCC_DIV2 = 3'b000,
    TCC_DIV8 = 3'b001,
    TCC_DIV32 = 3'b010,
    TCC_DIV128 = 3'b011,
    TCC_DIV1024 = 3'b100,
    TCC_XC0 = 3'b101,
    TCC_XC1 = 3'b110,
    TCC_XC2 = 3'b111
  } tcc_clksel_e;

endpackage

// ===== tb/tcc_timer_channel_props.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------
// Port checker for the channel
// ---------------------------------
module tcc_props (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // done
  input wire logic pslverr, // error
  input wire logic timer_line_a_out, // line A value
  input wire logic timer_line_a_oe, // line A enable
  input wire logic timer_line_b_oe, // line B enable
  input wire logic external_count_input_out, // count pin value
  input wire logic external_count_input_oe // count pin enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ack_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ack_follows_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  unmapped_err_a: assert property (pready && paddr == 12'h010 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  err_with_ack_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  wo_read_zero_a: assert property (pready && !pwrite && paddr == 12'h060 |-> prdata == 32'h0)
    else $error("command register kept data");
  capture_input_a: assert property (!timer_line_a_oe && !timer_line_b_oe)
    else $error("timer line driven in capture mode");
  drain_low_a: assert property (external_count_input_oe |-> !external_count_input_out)
    else $error("count pin driven high");
  out_by_write_a: assert property ($changed(timer_line_a_out) |-> $past(pready && pwrite, 2))
    else $error("line A value changed without write");
  cover property (pready && pwrite);
  cover property (pready && pslverr);
  cover property (external_count_input_oe);
endmodule

bind tcc_timer_channel tcc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_line_a_out(timer_line_a_out), .timer_line_a_oe(timer_line_a_oe),
  .timer_line_b_oe(timer_line_b_oe), .external_count_input_out(external_count_input_out),
  .external_count_input_oe(external_count_input_oe));
`default_nettype wire

// ===== tb/tcc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------
// External sources on the pins
// ---------------------------------
module tcc_pin_model (
  input wire logic k_out, // channel value on the count pin
  input wire logic k_oe, // channel enable on the count pin
  output logic pin_a, // level on line A
  output logic pin_b, // level on line B
  output logic pin_k, // level on the count pin
  output logic xc1, // external clock 1
  output logic xc2 // external clock 2
);
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  logic lvl_k = 1'b1;
  logic lvl_x1 = 1'b0;
  // The channel only pulls low, so its drive overrides the source.
  assign pin_k = k_oe ? k_out : lvl_k;
  assign pin_a = lvl_a;
  assign pin_b = lvl_b;
  // The clock stands still between bursts of pulses.
  assign xc1 = lvl_x1;
  assign xc2 = 1'b0;
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, err, timer_line_a_in, timer_line_b_in, external_count_input_in;
  logic timer_line_a_out, timer_line_a_oe, timer_line_b_out, timer_line_b_oe;
  logic external_count_input_out, external_count_input_oe, ext_clock_1, ext_clock_2;
  int fail_count = 0;
  int checks_done = 0;
  always #5 pclk = ~pclk;
  tcc_timer_channel dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_line_a_in, .timer_line_a_out, .timer_line_a_oe,
    .timer_line_b_in, .timer_line_b_out, .timer_line_b_oe, .external_count_input_in,
    .external_count_input_out, .external_count_input_oe, .ext_clock_1, .ext_clock_2);
  tcc_pin_model u_pin (.k_out(external_count_input_out), .k_oe(external_count_input_oe),
    .pin_a(timer_line_a_in), .pin_b(timer_line_b_in), .pin_k(external_count_input_in),
    .xc1(ext_clock_1), .xc2(ext_clock_2));
  // ---------------------------------
  // Bus, pin and check tasks
  // ---------------------------------
  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd & m);
  endtask
  task automatic pulse_a();
    u_pin.lvl_a <= 1'b1;
    repeat (8) @(posedge pclk);
    u_pin.lvl_a <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic pulse_x1(input int n);
    repeat (n) begin
      u_pin.lvl_x1 <= 1'b1;
      repeat (8) @(posedge pclk);
      u_pin.lvl_x1 <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
  // ---------------------------------
  // Tests
  // ---------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(12'h038, 32'hffffffff, 32'h0);
    rdc(12'h048, 32'hffffffff, 32'h0);
    rdc(12'h058, 32'hffffffff, 32'h0);
    rdc(12'h064, 32'hffffffff, 32'h0);
    rdc(12'h060, 32'hffffffff, 32'h0);
    xfer(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wr(12'h030, 32'h0007_0000);
    rdc(12'h038, 32'hffffffff, 32'h0007_0000);
    chk("count pin value", 32'h1, {31'h0, external_count_input_out});
    wr(12'h034, 32'h0002_0000);
    rdc(12'h038, 32'hffffffff, 32'h0005_0000);
    chk("line b out", 32'h1, {31'h0, timer_line_b_out});
    chk("line a out", 32'h0, {31'h0, timer_line_a_out});
    u_pin.lvl_a <= 1'b1;
    wr(12'h040, 32'h0004_0000);
    rdc(12'h048, 32'hffffffff, 32'h0004_0000);
    wr(12'h034, 32'h0004_0000);
    repeat (5) @(posedge pclk);
    rdc(12'h03c, 32'hffffffff, 32'h0002_0000);
    wr(12'h044, 32'h0004_0000);
    rdc(12'h048, 32'hffffffff, 32'h0);
    repeat (5) @(posedge pclk);
    rdc(12'h03c, 32'hffffffff, 32'h0006_0000);
    wr(12'h050, 32'h3);
    rdc(12'h058, 32'hffffffff, 32'h3);
    wr(12'h054, 32'h1);
    rdc(12'h058, 32'hffffffff, 32'h2);
    wr(12'h050, 32'h1);
    wr(12'h064, 32'h0);
    wr(12'h060, 32'h2);
    wr(12'h060, 32'h8);
    repeat (10) @(posedge pclk);
    xfer(1'b0, 12'h080, 32'h0);
    v = rd;
    xfer(1'b0, 12'h080, 32'h0);
    v = rd - v;
    chk("count step", 32'h2, v);
    rdc(12'h070, 32'h100, 32'h100);
    wr(12'h060, 32'h6);
    rdc(12'h070, 32'h100, 32'h0);
    wr(12'h060, 32'h2);
    wr(12'h08c, 32'h0040);
    rdc(12'h08c, 32'hffffffff, 32'h40);
    wr(12'h060, 32'h8);
    repeat (200) @(posedge pclk);
    rdc(12'h070, 32'h10, 32'h10);
    rdc(12'h070, 32'h10, 32'h0);
    u_pin.lvl_a <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(12'h064, 32'h400 | (c << 8));
      xfer(1'b0, 12'h070, 32'h0);
      u_pin.lvl_a <= 1'b1;
      repeat (8) @(posedge pclk);
      rdc(12'h070, 32'h80, c[0] << 7);
      u_pin.lvl_a <= 1'b0;
      repeat (8) @(posedge pclk);
      rdc(12'h070, 32'h80, c[1] << 7);
    end
    wr(12'h064, 32'h0001_0000);
    xfer(1'b0, 12'h084, 32'h0);
    xfer(1'b0, 12'h070, 32'h0);
    pulse_a();
    pulse_a();
    rdc(12'h070, 32'h22, 32'h22);
    xfer(1'b0, 12'h084, 32'h0);
    chk("capture a", 32'h1, {31'h0, rd[15:0] != 16'h0});
    wr(12'h064, 32'h0009_0080);
    u_pin.lvl_a <= 1'b1;
    repeat (8) @(posedge pclk);
    u_pin.lvl_a <= 1'b0;
    repeat (8) @(posedge pclk);
    rdc(12'h070, 32'h140, 32'h040);
    wr(12'h060, 32'h2);
    wr(12'h064, 32'h6);
    wr(12'h300, 32'h1);
    pulse_x1(6);
    rdc(12'h080, 32'hffff, 32'h5);
    u_pin.lvl_k <= 1'b0;
    wr(12'h064, 32'h16);
    pulse_x1(2);
    u_pin.lvl_k <= 1'b1;
    rdc(12'h080, 32'hffff, 32'h5);
    pulse_x1(1);
    rdc(12'h080, 32'hffff, 32'h6);
    wr(12'h030, 32'h0001_0000);
    wr(12'h060, 32'h1);
    rdc(12'h038, 32'hffffffff, 32'h0);
    rdc(12'h064, 32'hffffffff, 32'h0);
    rdc(12'h058, 32'hffffffff, 32'h3);
    wrap_up();
  end
endmodule
`default_nettype wire
